// ===== hw/residual_overcurrent_timing.sv
// residual overcurrent element: pickup, definite and inverse timing, decision, apb slave
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "residual_oc_consts.svh"
module residual_overcurrent_timing
    import residual_oc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `MS_TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] residual_fourier_magnitude,
    input wire logic block_input,
    output logic general_start_out,
    output logic general_trip_out,
    output logic irq
);
    settings_s set_reg;
    phase_e phase_reg;
    logic [15:0] ms_cnt_reg;
    logic [15:0] rst_cnt_reg;
    logic [39:0] acc_reg;
    logic internal_start_reg, internal_trip_reg;
    logic general_start_reg, general_trip_reg;
    logic [1:0] int_status_reg, int_mask_reg;
    logic irq_reg, pready_reg, pslverr_reg;
    logic [31:0] prdata_reg;
    logic tick;
    curve_s curve;
    logic mode_on, is_def, is_inv, over, trip_cond;
    logic c_done, k_done, min_done, def_done;
    logic [15:0] mag_lim;
    logic [16:0] ratio;
    logic [25:0] drive;
    logic [31:0] rd_next;
    logic err_next;
    logic wr_acc;
    logic [1:0] int_status_next;

    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
        if (v < lo) return lo;
        if (v > hi) return hi;
        return v;
    endfunction

    // log2 of a Q12 ratio in [1,32), linear between powers of two
    function automatic logic [14:0] log2_q12(input logic [16:0] r);
        logic [2:0] e;
        logic [16:0] m;
        e = 3'h0;
        for (int i = 13; i <= 16; i++) begin
            if (r[i]) e = 3'(i - 12);
        end
        m = r >> e;
        return {e, m[11:0]};
    endfunction

    // per-ms integration step in Q16: ratio^alpha - 1
    function automatic logic [25:0] drive_q16(input alpha_e a, input logic [16:0] r);
        logic [33:0] sq;
        logic [24:0] lg;
        sq = 34'(r) * 34'(r);
        lg = 25'(log2_q12(r)) * 25'h00_00E3;
        case (a)
            ALPHA_1: return 26'({r - 17'h0_1000, 4'h0});
            ALPHA_2: return sq[33:8] - 26'h001_0000;
            default: return 26'(lg >> 10);
        endcase
    endfunction

    // curve constants: k scaled by 655360, c scaled by 100000
    function automatic curve_s curve_of(input op_t op);
        case (op)
            4'h2: return '{27'h001_6666, 17'h0_0000, ALPHA_002};
            4'h3: return '{27'h087_0000, 17'h0_0000, ALPHA_1};
            4'h4: return '{27'h320_0000, 17'h0_0000, ALPHA_2};
            4'h5: return '{27'h4B0_0000, 17'h0_0000, ALPHA_1};
            4'h6: return '{27'h000_1604, 17'h0_073A, ALPHA_002};
            4'h7: return '{27'h000_83D7, 17'h0_2C88, ALPHA_002};
            4'h8: return '{27'h0C4_199A, 17'h0_BFCC, ALPHA_2};
            4'h9: return '{27'h11A_0000, 17'h0_2F8A, ALPHA_2};
            4'hA: return '{27'h000_DC29, 17'h0_4844, ALPHA_002};
            4'hB: return '{27'h11D_8000, 17'h1_1620, ALPHA_2};
            4'hC: return '{27'h280_B333, 17'h0_61A8, ALPHA_2};
            default: return '{27'h000_0000, 17'h0_0000, ALPHA_002};
        endcase
    endfunction

    ms_tick_gen #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    // mode decode and pickup; a ratio of 1+5/4096 or more integrates on every curve, so 1.1x surely operates
    assign mode_on = set_reg.op != `OP_OFF;
    assign is_def = set_reg.op == `OP_DEF;
    assign is_inv = mode_on & ~is_def;
    assign over = mode_on & (residual_fourier_magnitude > 16'(set_reg.start));

    // ratio clamped at twenty times start, so heavy faults see the twenty-times delay
    assign mag_lim = (residual_fourier_magnitude > 16'(set_reg.start) * `RATIO_LIMIT) ?
                     16'(set_reg.start) * `RATIO_LIMIT : residual_fourier_magnitude;
    assign ratio = 17'({mag_lim, 12'h000} / 28'(set_reg.start));
    assign curve = curve_of(set_reg.op);
    assign drive = drive_q16(curve.alpha, ratio);

    // expiry tests; the multiplier scales both curve terms
    assign c_done = 32'(ms_cnt_reg) * `C_SCALE >= 32'(set_reg.tms) * 32'(curve.cu);
    assign k_done = acc_reg >= 40'(set_reg.tms) * 40'(curve.kq);
    assign min_done = ms_cnt_reg >= set_reg.min_dly;
    assign def_done = ms_cnt_reg >= set_reg.def_dly;
    assign trip_cond = over & (phase_reg == TP_RUN) &
                       (is_def ? def_done : (c_done & k_done & min_done));

    // timing phase and counters; block or definite dropout clears at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= TP_IDLE;
            ms_cnt_reg <= 16'h0000;
            rst_cnt_reg <= 16'h0000;
            acc_reg <= 40'h00_0000_0000;
        end else if (block_input | ~mode_on | (~over & is_def)) begin
            phase_reg <= TP_IDLE;
            ms_cnt_reg <= 16'h0000;
            rst_cnt_reg <= 16'h0000;
            acc_reg <= 40'h00_0000_0000;
        end else begin
            case (phase_reg)
                TP_IDLE: begin
                    if (over) phase_reg <= TP_RUN;
                end
                TP_RUN: begin
                    if (!over) begin
                        phase_reg <= TP_HOLD;
                        rst_cnt_reg <= 16'h0000;
                    end else if (tick) begin
                        if (ms_cnt_reg != 16'hFFFF) ms_cnt_reg <= ms_cnt_reg + 16'h0001;
                        // stop integrating once expired, so the sum cannot wrap
                        if (c_done & ~k_done) acc_reg <= acc_reg + 40'(drive);
                    end
                end
                TP_HOLD: begin
                    if (over) begin
                        phase_reg <= TP_RUN;
                    end else if (tick) begin
                        if (rst_cnt_reg + 16'h0001 >= set_reg.rst_dly) begin
                            phase_reg <= TP_IDLE;
                            ms_cnt_reg <= 16'h0000;
                            rst_cnt_reg <= 16'h0000;
                            acc_reg <= 40'h00_0000_0000;
                        end else begin
                            rst_cnt_reg <= rst_cnt_reg + 16'h0001;
                        end
                    end
                end
                default: phase_reg <= TP_IDLE;
            endcase
        end
    end

    // internal indications, then the decision stage gated by block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            internal_start_reg <= 1'b0;
            internal_trip_reg <= 1'b0;
            general_start_reg <= 1'b0;
            general_trip_reg <= 1'b0;
        end else begin
            internal_start_reg <= over & ~block_input;
            internal_trip_reg <= trip_cond & ~block_input;
            general_start_reg <= internal_start_reg & ~block_input;
            general_trip_reg <= internal_trip_reg & ~block_input;
        end
    end

    // apb read mux, decoded in the setup cycle
    always_comb begin
        rd_next = 32'h0000_0000;
        err_next = 1'b0;
        if (paddr[31:8] != 24'h00_0000) begin
            err_next = 1'b1;
        end else begin
            case (paddr[7:0])
                `OFF_OPER: rd_next = 32'(set_reg.op);
                `OFF_START: rd_next = 32'(set_reg.start);
                `OFF_TMS: rd_next = 32'(set_reg.tms);
                `OFF_MIN_DLY: rd_next = 32'(set_reg.min_dly);
                `OFF_DEF_DLY: rd_next = 32'(set_reg.def_dly);
                `OFF_RST_DLY: rd_next = 32'(set_reg.rst_dly);
                `OFF_STATE: begin
                    rd_next[`ST_INT_START] = internal_start_reg;
                    rd_next[`ST_INT_TRIP] = internal_trip_reg;
                    rd_next[`ST_GEN_START] = general_start_reg;
                    rd_next[`ST_GEN_TRIP] = general_trip_reg;
                    rd_next[`ST_BLOCK] = block_input;
                    rd_next[`ST_HOLD] = phase_reg == TP_HOLD;
                end
                `OFF_INT_STATUS: rd_next = 32'(int_status_reg);
                `OFF_INT_MASK: rd_next = 32'(int_mask_reg);
                `OFF_MEAS: rd_next = 32'(residual_fourier_magnitude);
                default: err_next = 1'b1;
            endcase
        end
    end

    // zero wait state: ready rises for exactly the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= psel & ~penable;
            if (psel & ~penable) begin
                pslverr_reg <= err_next;
                prdata_reg <= pwrite ? 32'h0000_0000 : rd_next;
            end else begin
                pslverr_reg <= 1'b0;
            end
        end
    end

    assign wr_acc = psel & penable & pready_reg & pwrite & ~pslverr_reg;

    // settings, clamped into range; unknown operation codes are ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            set_reg <= '{`OP_OFF, `START_RST, `TMS_RST, `DLY_RST, `DLY_RST, `DLY_RST};
        end else if (wr_acc) begin
            case (paddr[7:0])
                `OFF_OPER: if (pwdata[3:0] <= `OP_LAST) set_reg.op <= pwdata[3:0];
                `OFF_START: set_reg.start <= 11'(clamp16(pwdata[15:0], `START_MIN, `START_MAX));
                `OFF_TMS: set_reg.tms <= 11'(clamp16(pwdata[15:0], `TMS_MIN, `TMS_MAX));
                `OFF_MIN_DLY:
                    set_reg.min_dly <= clamp16(pwdata[15:0], `DLY_MIN, `DLY_MAX);
                `OFF_DEF_DLY:
                    set_reg.def_dly <= clamp16(pwdata[15:0], `DLY_MIN, `DLY_MAX);
                `OFF_RST_DLY: set_reg.rst_dly <= clamp16(pwdata[15:0], `RST_DLY_MIN, `DLY_MAX);
                default: ;
            endcase
        end
    end

    // sticky events on output rising edges; a new event beats the clearing write
    always_comb begin
        int_status_next = int_status_reg;
        if (wr_acc && paddr[7:0] == `OFF_INT_STATUS) int_status_next &= ~pwdata[1:0];
        int_status_next[`IRQ_START] |= internal_start_reg & ~block_input & ~general_start_reg;
        int_status_next[`IRQ_TRIP] |= internal_trip_reg & ~block_input & ~general_trip_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status_reg <= 2'h0;
            int_mask_reg <= 2'h0;
            irq_reg <= 1'b0;
        end else begin
            int_status_reg <= int_status_next;
            if (wr_acc && paddr[7:0] == `OFF_INT_MASK) int_mask_reg <= pwdata[1:0];
            irq_reg <= |(int_status_reg & int_mask_reg);
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign general_start_out = general_start_reg;
    assign general_trip_out = general_trip_reg;
    assign irq = irq_reg;

    // checks next to the logic they guard
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    off_quiet_a: assert property (!mode_on
                                  |=> !internal_start_reg && !internal_trip_reg)
        else $error("element active while operation is off");
    start_follow_a: assert property (over && !block_input |=> internal_start_reg)
        else $error("internal start missing while over threshold");
    block_outputs_a: assert property (block_input
                                      |=> !general_start_out && !general_trip_out)
        else $error("outputs active while blocked");
    def_delay_a: assert property ($rose(internal_trip_reg) && $past(is_def)
                                  |-> $past(ms_cnt_reg) >= $past(set_reg.def_dly))
        else $error("definite trip before delay");
    min_floor_a: assert property ($rose(internal_trip_reg) && $past(is_inv)
                                  |-> $past(ms_cnt_reg) >= $past(set_reg.min_dly))
        else $error("inverse trip before minimum delay");
    timer_clear_a: assert property (block_input
                                    |=> ms_cnt_reg == 16'h0000 && acc_reg == 40'h0)
        else $error("timers not cleared by block");
    reset_hold_a: assert property (phase_reg == TP_HOLD
                                   |-> rst_cnt_reg < set_reg.rst_dly)
        else $error("reset delay overrun");
    ratio_limit_a: assert property (ratio <= 17'h1_4000)
        else $error("ratio exceeds twenty");
    tms_range_a: assert property (set_reg.tms >= 11'h005 && set_reg.tms <= 11'h5DC)
        else $error("time multiplier out of range");
    decision_trip_a: assert property (internal_trip_reg && !block_input
                                      |=> general_trip_out ##0 $past(internal_trip_reg, 1))
        else $error("general trip not following internal trip");
    irq_level_a: assert property (|(int_status_reg & int_mask_reg) |=> irq)
        else $error("interrupt missing");

    def_trip_c: cover property (is_def && $rose(general_trip_out));
    inv_trip_c: cover property (is_inv && $rose(general_trip_out));
    hold_resume_c: cover property (phase_reg == TP_HOLD ##1 phase_reg == TP_RUN);
endmodule // residual_overcurrent_timing

// ===== hw/residual_oc_consts.svh
// offsets, field positions, reset values and timing counts of the residual overcurrent element
`ifndef RESIDUAL_OC_CONSTS_SVH
`define RESIDUAL_OC_CONSTS_SVH
// register byte offsets
`define OFF_OPER 8'h00
`define OFF_START 8'h04
`define OFF_TMS 8'h08
`define OFF_MIN_DLY 8'h0C
`define OFF_DEF_DLY 8'h10
`define OFF_RST_DLY 8'h14
`define OFF_STATE 8'h18
`define OFF_INT_STATUS 8'h1C
`define OFF_INT_MASK 8'h20
`define OFF_MEAS 8'h24
// state register bit positions
`define ST_INT_START 0
`define ST_INT_TRIP 1
`define ST_GEN_START 2
`define ST_GEN_TRIP 3
`define ST_BLOCK 4
`define ST_HOLD 5
// interrupt status and mask bit positions
`define IRQ_START 0
`define IRQ_TRIP 1
// operation selection codes
`define OP_OFF 4'h0
`define OP_DEF 4'h1
`define OP_LAST 4'hC
// setting ranges and reset values
`define START_MIN 16'h0005
`define START_MAX 16'h03E8
`define START_RST 11'h032
`define TMS_MIN 16'h0005
`define TMS_MAX 16'h05DC
`define TMS_RST 11'h064
`define DLY_MIN 16'h0028
`define RST_DLY_MIN 16'h003C
`define DLY_MAX 16'hEA60
`define DLY_RST 16'h0064
// curve arithmetic
`define RATIO_LIMIT 16'h0014
`define C_SCALE 32'h0000_2710
// one millisecond tick at a 5 ns clock
`define CLK_PERIOD_NS 5
`define MS_NS 1000000
`define MS_TICK_CYCLES (`MS_NS / `CLK_PERIOD_NS)
`endif

// ===== hw/residual_oc_pkg.sv
// types shared by the residual overcurrent element
package residual_oc_pkg;
    typedef logic [3:0] op_t;
    typedef enum logic [1:0] {ALPHA_002, ALPHA_1, ALPHA_2} alpha_e;
    typedef enum logic [1:0] {TP_IDLE, TP_RUN, TP_HOLD} phase_e;
    typedef struct packed {
        op_t op;
        logic [10:0] start;
        logic [10:0] tms;
        logic [15:0] min_dly;
        logic [15:0] def_dly;
        logic [15:0] rst_dly;
    } settings_s;
    typedef struct packed {
        logic [26:0] kq;
        logic [16:0] cu;
        alpha_e alpha;
    } curve_s;
endpackage

// ===== hw/ms_tick_gen.sv
// millisecond enable pulse divided down from the system clock
`timescale 1ns/1ps
module ms_tick_gen #(
    parameter int unsigned CYCLES = 200000
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    logic [31:0] cnt_reg;
    logic tick_reg;

    // free running divider, one pulse every CYCLES clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 32'h0000_0000;
            tick_reg <= 1'b0;
        end else if (cnt_reg >= 32'(CYCLES - 1)) begin
            cnt_reg <= 32'h0000_0000;
            tick_reg <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
            tick_reg <= 1'b0;
        end
    end

    assign tick = tick_reg;
endmodule // ms_tick_gen

// ===== verification/meas_partner.sv
// far-side model: measurement filter output and user block equation
`timescale 1ns/1ps
module meas_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] want_mag,
    input wire logic want_blk,
    input wire logic slow,
    output logic [15:0] mag,
    output logic blk
);
    logic [15:0] gap;

    // distance left to the target, for the settling ramp
    assign gap = (mag > want_mag) ? mag - want_mag : want_mag - mag;

    // jump or ramp in steps, the way a filter output settles after a change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mag <= 16'h0000;
        end else if (!slow || gap < 16'h0040) begin
            mag <= want_mag;
        end else if (mag < want_mag) begin
            mag <= mag + 16'h0040;
        end else begin
            mag <= mag - 16'h0040;
        end
    end

    // user equation result, a plain level held until the equation changes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blk <= 1'b0;
        end else begin
            blk <= want_blk;
        end
    end
endmodule // meas_partner

// ===== verification/residual_overcurrent_timing_tb.sv
// self-checking bench for the residual overcurrent element
`timescale 1ns/1ps
`include "residual_oc_consts.svh"
module residual_overcurrent_timing_tb;
    import residual_oc_pkg::*;
    localparam int TK = 10;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [15:0] mag, want_mag;
    logic blk, want_blk, slow, gs, gt, irq;
    int err_total = 0, samples_checked = 0, cyc = 0, n, st, dl;
    real x;
    real kk [11] = '{0.14, 13.5, 80.0, 120.0, 0.0086, 0.0515, 19.61, 28.2, 0.086, 28.55, 64.07};
    real cc [11] = '{0.0, 0.0, 0.0, 0.0, 0.0185, 0.114, 0.491, 0.1217, 0.185, 0.712, 0.25};
    real aa [11] = '{0.02, 1.0, 2.0, 1.0, 0.02, 0.02, 2.0, 2.0, 0.02, 2.0, 2.0};
    logic [7:0] c_off [5] = '{`OFF_TMS, `OFF_MIN_DLY, `OFF_DEF_DLY, `OFF_RST_DLY, `OFF_TMS};
    logic [31:0] c_wr [5] = '{32'h0000_0001, 32'h0, 32'h0, 32'h0, 32'h0000_0640};
    logic [31:0] c_ex [5] = '{32'h0000_0005, 32'h0000_0028, 32'h0000_0028, 32'h0000_003C,
        32'h0000_05DC};

    residual_overcurrent_timing #(.TICK_CYCLES(TK)) i_residual_overcurrent_timing (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .residual_fourier_magnitude(mag), .block_input(blk), .general_start_out(gs),
        .general_trip_out(gt), .irq(irq));
    meas_partner i_meas_partner (.pclk(pclk), .presetn(presetn), .want_mag(want_mag),
        .want_blk(want_blk), .slow(slow), .mag(mag), .blk(blk));

    // 200 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // hang guard, far above the longest expected run
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            $display("mismatch at %0t: run timed out", $time);
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi, input string what);
        samples_checked++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("mismatch at %0t: %s took %0d, allowed %0d..%0d", $time, what, got, lo, hi);
        end
    endtask

    // inverse operate time, t in cycles, with room for the curve approximation
    task automatic chk_inv(input int got, input real t, input string what);
        chk_rng(got, int'(t * 0.92) - 20, int'(t * 1.08) + 30, what);
    endtask

    // one apb transfer; waits for pready, never assumes the wait length
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int w;
        w = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            w++;
        end while (pready !== 1'b1 && w < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (w == 20) begin
            chk(32'h0, 32'h1, "apb answer");
            finish_test();
        end
    endtask

    task automatic drive(input logic [15:0] m, input logic b, input logic s);
        @(posedge pclk);
        want_mag <= m;
        want_blk <= b;
        slow <= s;
    endtask

    // edges until start (0), trip (1) or irq (2) shows level v
    task automatic wait_out(input int which, input logic v, input int lim, output int c);
        logic s;
        c = 0;
        do begin
            @(posedge pclk);
            c++;
            s = (which == 0) ? gs : (which == 1) ? gt : irq;
        end while (s !== v && c < lim);
    endtask

    // expected inverse operate time in ms at g times start, floored
    function automatic real inv_ms(input int i, input real g, input real tms, input real mn);
        real t;
        t = 1000.0 * tms * (kk[i] / (g ** aa[i] - 1.0) + cc[i]);
        return (t < mn) ? mn : t;
    endfunction

    initial begin
        {psel, penable, pwrite, want_blk, slow} = '0;
        {paddr, pwdata, want_mag} = '0;
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        void'($urandom(32'haee4));
        // reset values, unmapped access, clamps, illegal operation code
        apb(0, `OFF_OPER, 0);
        chk(rd, 32'h0, "oper reset");
        for (int i = 0; i < 5; i++) begin
            apb(0, 8'(4 + 4 * i), 0);
            chk(rd, (i == 0) ? 32'h32 : 32'h64, "reset");
        end
        apb(0, 8'h28, 0);
        chk({rd[30:0], er}, 32'h1, "unmapped read");
        for (int i = 0; i < 5; i++) begin
            apb(1, c_off[i], c_wr[i]);
            apb(0, c_off[i], 0);
            chk(rd, c_ex[i], "setting clamp");
        end
        apb(1, `OFF_OPER, 32'h0000_0001);
        apb(1, `OFF_OPER, 32'h0000_000D);
        apb(0, `OFF_OPER, 0);
        chk(rd, 32'h1, "oper code out of range");
        $display("test registers done");
        // definite time with random settings, interrupts, block
        apb(1, `OFF_INT_MASK, 32'h0000_0003);
        for (int t = 0; t < 3; t++) begin
            st = 20 + $urandom_range(180);
            dl = 40 + $urandom_range(20);
            apb(1, `OFF_START, 32'(st));
            apb(1, `OFF_DEF_DLY, 32'(dl));
            drive(16'((t == 0) ? st + 1 : st + 1 + $urandom_range(998 - st)), 1'b0, 1'b0);
            wait_out(0, 1'b1, 20, n);
            chk_rng(n, 3, 5, "start delay");
            wait_out(1, 1'b1, dl * TK + 40, n);
            chk_rng(n, dl * TK - TK - 4, dl * TK + TK + 4, "definite trip");
            apb(0, `OFF_INT_STATUS, 0);
            chk(rd, 32'h3, "event status");
            chk({31'h0, irq}, 32'h1, "irq raised");
            apb(1, `OFF_INT_STATUS, 32'h0000_0003);
            wait_out(2, 1'b0, 6, n);
            chk_rng(n, 1, 5, "irq cleared");
            drive(want_mag, 1'b1, 1'b0);
            wait_out(0, 1'b0, 8, n);
            chk_rng(n, 2, 5, "block drop");
            repeat (dl * TK + 20) @(posedge pclk);
            chk({30'h0, gs, gt}, 32'h0, "held blocked");
            apb(0, `OFF_STATE, 0);
            chk(rd, 32'h0000_0010, "blocked state");
            drive(16'h0000, 1'b0, 1'b0);
            repeat (6) @(posedge pclk);
        end
        $display("test definite done");
        // equal to threshold by a slow ramp, then just above with events masked
        apb(1, `OFF_INT_MASK, 32'h0);
        drive(16'(st), 1'b0, 1'b1);
        repeat (200) @(posedge pclk);
        chk({31'h0, gs}, 32'h0, "no start at threshold");
        apb(0, `OFF_MEAS, 0);
        chk(rd, 32'(st), "measured magnitude");
        drive(16'(st + 1), 1'b0, 1'b0);
        wait_out(0, 1'b1, 20, n);
        chk_rng(n, 3, 5, "start just above");
        chk({31'h0, irq}, 32'h0, "masked irq");
        apb(0, `OFF_INT_STATUS, 0);
        chk(rd, 32'h1, "masked status");
        drive(16'h0000, 1'b0, 1'b0);
        $display("test threshold done");
        // every inverse curve at and above the twenty times clamp
        apb(1, `OFF_START, 32'h0000_0032);
        apb(1, `OFF_TMS, 32'h0000_0005);
        apb(1, `OFF_MIN_DLY, 32'h0000_0028);
        apb(1, `OFF_RST_DLY, 32'h0000_003C);
        for (int i = 0; i < 11; i++) begin
            apb(1, `OFF_OPER, 32'(i + 2));
            drive(16'h03E8 + 16'($urandom_range(1000)), 1'b0, 1'b0);
            wait_out(1, 1'b1, 8000, n);
            x = inv_ms(i, 20.0, 0.05, 40.0) * TK;
            chk_inv(n, x, "inverse trip");
            drive(16'h0000, 1'b1, 1'b0);
            repeat (4) @(posedge pclk);
            drive(16'h0000, 1'b0, 1'b0);
        end
        // ten times start, below the clamp, so the ratio itself sets the delay
        apb(1, `OFF_OPER, 32'h0000_0003);
        drive(16'h01F4, 1'b0, 1'b0);
        wait_out(1, 1'b1, 8000, n);
        chk_inv(n, inv_ms(1, 10.0, 0.05, 40.0) * TK, "inverse at ten");
        drive(16'h0000, 1'b1, 1'b0);
        repeat (4) @(posedge pclk);
        drive(16'h0000, 1'b0, 1'b0);
        $display("test inverse done");
        // short dropout inside the reset delay keeps the elapsed part
        apb(1, `OFF_OPER, 32'h0000_0005);
        drive(16'h03E8, 1'b0, 1'b0);
        repeat (100 * TK) @(posedge pclk);
        drive(16'h0000, 1'b0, 1'b0);
        repeat (30 * TK) @(posedge pclk);
        apb(0, `OFF_STATE, 0);
        chk(rd, 32'h0000_0020, "reset hold state");
        drive(16'h03E8, 1'b0, 1'b0);
        wait_out(1, 1'b1, 8000, n);
        x = (inv_ms(3, 20.0, 0.05, 40.0) - 100.0) * TK;
        chk_inv(n, x, "trip after dropout");
        $display("test reset delay done");
        finish_test();
    end
endmodule // residual_overcurrent_timing_tb
